// ===== srcp_command_port_sva.sv
// Concurrent checks on the SPI command port pins
`timescale 1ns/1ps
module srcp_command_port_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       slave_select_n,
  input wire logic       mosi_oe_n,
  input wire logic       miso_oe_n,
  input wire logic [3:0] general_outputs,
  input wire logic       oscillator_input,
  input wire logic       oscillator_output,
  input wire logic       interrupt_out,
  input wire logic       interrupt_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Frame steps
  sequence frame_open;
    $fell(slave_select_n);
  endsequence
  sequence frame_close;
    $rose(slave_select_n);
  endsequence
  // Two spare cycles let a release after select rises land
  sequence link_idle;
    slave_select_n [*3];
  endsequence

  // ==========================================================================
  // Pin checks
  miso_idle_a: assert property (link_idle |-> miso_oe_n)
    else $error("miso driven while deselected");
  mosi_idle_a: assert property (link_idle |-> mosi_oe_n)
    else $error("mosi driven while deselected");
  duplex_excl_a: assert property (!miso_oe_n |-> mosi_oe_n)
    else $error("both data lines driven");
  cmd_phase_a: assert property (frame_open |-> mosi_oe_n [*8])
    else $error("mosi driven during command byte");
  frame_release_a: assert property (frame_close |-> ##[1:3] (miso_oe_n && mosi_oe_n))
    else $error("drivers held after frame end");
  osc_invert_a: assert property (oscillator_output == !oscillator_input)
    else $error("oscillator output not inverted input");
  irq_drain_a: assert property (interrupt_oe_n |-> !interrupt_out)
    else $error("open drain interrupt drives high");
  gpo_quiet_a: assert property (slave_select_n [*8] |=> $stable(general_outputs))
    else $error("outputs changed without a transfer");
endmodule

// ===== srcp_defs.svh
// Register indices, field positions, masks and clock figures of the SPI command port
`ifndef SRCP_DEFS_SVH
`define SRCP_DEFS_SVH

// ==========================================================================
// Register map
`define SRCP_REG_COUNT          21
`define SRCP_LAST_FIFO_REG      5'h04
`define SRCP_LAST_REG           5'h14
`define SRCP_REG_EP_STALL       5'h09
`define SRCP_REG_EP_EVENT       5'h0b
`define SRCP_REG_EP_ENABLE      5'h0c
`define SRCP_REG_USB_EVENT      5'h0d
`define SRCP_REG_USB_ENABLE     5'h0e
`define SRCP_REG_CPU_CTL        5'h10
`define SRCP_REG_PIN_CTL        5'h11
`define SRCP_REG_REVISION       5'h12
`define SRCP_REG_FN_ADDR        5'h13
`define SRCP_REG_IO_PIN         5'h14
`define SRCP_REG_BYTE_COUNT_LO  5'h05
`define SRCP_REG_BYTE_COUNT_HI  5'h08
`define SRCP_REG_TOGGLES        5'h0a
`define SRCP_REG_USB_CTL        5'h0f

// ==========================================================================
// Field positions
`define SRCP_ACK_BIT            6
`define SRCP_FULL_DUPLEX_BIT    4
`define SRCP_INT_LEVEL_BIT      3
`define SRCP_INT_POS_BIT        2
`define SRCP_INT_ENABLE_BIT     0
`define SRCP_SUSPEND_BIT        4
`define SRCP_BUS_RESET_BIT      3
`define SRCP_VBUS_ON_BIT        6
`define SRCP_VBUS_OFF_BIT       5

// ==========================================================================
// Writable bits per register
`define SRCP_MASK_ALL           8'hff
`define SRCP_MASK_LOW7          8'h7f
`define SRCP_MASK_LOW6          8'h3f
`define SRCP_MASK_HIGH6         8'hfc
`define SRCP_MASK_BIT0          8'h01
`define SRCP_MASK_NONE          8'h00
`define SRCP_MASK_GP_OUT        8'h0f

// ==========================================================================
// Clocks
`define SRCP_SYS_CLK_HZ         20000000
`define SRCP_CORE_CLK_HZ        12000000

`endif

// ===== srcp_pkg.sv
// Types shared by the SPI command port design
package srcp_pkg;

  // ========================================================================
  // Command byte as it arrives on the link
  typedef struct packed {
    logic [4:0] reg_sel;
    logic       zero;
    logic       write;
    logic       ack;
  } srcp_command_type;

  // ========================================================================
  // USB engine events, in status byte order
  typedef struct packed {
    logic suspend_event;
    logic bus_reset_event;
    logic setup_data_ready_event;
    logic ep3_in_buffer_free_event;
    logic ep2_in_buffer_free_event;
    logic ep1_out_data_ready_event;
    logic ep0_out_data_ready_event;
    logic ep0_in_buffer_free_event;
  } srcp_usb_event_type;

  // ========================================================================
  // Written byte handed from the link to the core
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } srcp_link_word_type;

  typedef enum logic {
    srcp_phase_command,
    srcp_phase_data
  } srcp_phase_type;

endpackage

// ===== srcp_spi_master_model.sv
// SPI master model driving the command port link
`timescale 1ns/1ps
module srcp_spi_master_model (
  output logic      spi_clk,
  output logic      slave_select_n,
  output logic      mosi_in,
  input  wire logic mosi_out,
  input  wire logic mosi_oe_n,
  input  wire logic miso_out,
  input  wire logic miso_oe_n
);
  logic m_bit;
  logic m_drv;

  // Released line shows the inverse of the last bit, never a held value
  assign mosi_in = !mosi_oe_n ? mosi_out : (m_drv ? m_bit : ~m_bit);

  initial begin
    spi_clk = 1'b0;
    slave_select_n = 1'b1;
    m_bit = 1'b0;
    m_drv = 1'b0;
  end

  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    slave_select_n = 1'b0;
    #200;
    foreach (tx[i]) begin
      m_drv = (i == 0) || tx[0][1];
      for (int k = 7; k >= 0; k--) begin
        m_bit = tx[i][k];
        #40 spi_clk = 1'b1;
        // Undriven miso reads as the inverse, so a missing enable shows up
        b[k] = !mosi_oe_n ? mosi_out : (!miso_oe_n ? miso_out : ~miso_out);
        #40 spi_clk = 1'b0;
      end
      rx.push_back(b);
    end
    #40 slave_select_n = 1'b1;
    m_drv = 1'b0;
    #250;
  endtask
endmodule

// ===== srcp_spi_register_command_port.sv
// SPI slave command port with register file, status byte and pin reporting
// Functional notes
// - Each access is one command byte, then data bytes written or read.
// - All link bytes shift most significant bit first.
// - Command bits 7..3 hold register number, bit 2 is zero.
// - Command bit 1 high writes data bytes, low reads them.
// - Command bit 0 high sets the control-transfer acknowledge bit in register 9.
// - Twenty-one registers are reachable through the command protocol.
// - Full-duplex mode shifts out eight status bits during the command byte.
// - Status order: suspend, bus reset, setup, ep3 in, ep2 in, ep1 out, ep0 out, ep0 in.
// - Half-duplex mode returns no status byte; status is read from registers.
// - Register 20 bits 7..4 read the four general inputs, input 3 on top.
// - Writes to general input bits of register 20 are ignored.
// - Bus power appearing and vanishing shows in an interrupt and register bits.
// - Core runs from crystal or external clock on the oscillator input; the core logic here runs on sys_clk instead.
// - Data captured on rising serial clock, output changed on falling.
// - Select low frames a transfer; clock edges ignored while select is high.
// - Data output floats in half-duplex or when deselected; data input turns two-way.
// - Registers 0..4 keep address per byte; higher ones increment, stopping at 20.
`include "srcp_defs.svh"
`timescale 1ns/1ps
module srcp_spi_register_command_port #(
  // Arbitrary revision value
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         spi_clk,
  input  wire logic                         slave_select_n,
  input  wire logic                         mosi_in,
  output logic                              mosi_out,
  output logic                              mosi_oe_n,
  output logic                              miso_out,
  output logic                              miso_oe_n,
  input  wire logic [3:0]                   general_inputs,
  output logic      [3:0]                   general_outputs,
  input  wire logic                         bus_power_compare_input,
  input  wire logic                         oscillator_input,
  output logic                              oscillator_output,
  input  wire srcp_pkg::srcp_usb_event_type usb_events,
  output logic                              interrupt_out,
  output logic                              interrupt_oe_n
);

  // ========================================================================
  // Declarations
  logic                         link_rst;
  logic [2:0]                   bit_cnt_q;
  logic [6:0]                   shift_q;
  logic [7:0]                   rx_byte;
  logic                         byte_done;
  srcp_pkg::srcp_phase_type     in_phase_q;
  srcp_pkg::srcp_phase_type     out_phase_q;
  logic [2:0]                   out_cnt_q;
  logic [4:0]                   addr_q;
  logic                         write_q;
  srcp_pkg::srcp_command_type   cmd;
  logic                         wr_tgl_q;
  logic                         ack_tgl_q;
  srcp_pkg::srcp_link_word_type wr_word_q;
  logic [7:0]                   status_byte;
  logic [7:0]                   rd_byte;
  logic [7:0]                   tx_byte;
  logic                         tx_bit;
  logic                         full_duplex;

  logic                         select_n_s;
  logic [6:0]                   cross_in;
  logic [6:0]                   cross_s;
  logic [3:0]                   gpin_s;
  logic                         vbus_s;
  logic                         wr_tgl_s;
  logic                         ack_tgl_s;
  logic                         wr_tgl_prev_q;
  logic                         ack_tgl_prev_q;
  logic                         vbus_prev_q;
  logic                         wr_event;
  logic                         ack_event;
  logic                         vbus_rise;
  logic                         vbus_fall;
  logic [7:0]                   regs_q [0:`SRCP_REG_COUNT-1];
  logic [7:0]                   regs_d [0:`SRCP_REG_COUNT-1];
  logic [7:0]                   snap_q [0:`SRCP_REG_COUNT-1];
  logic                         irq_pending;
  logic                         irq_active_q;
  logic [3:0]                   gpout_q;

  // ========================================================================
  // Oscillator
  // Inverting amplifier across the crystal; an external clock drives the
  // input alone and the output is left open. The core logic itself runs
  // on sys_clk, a separate input that this amplifier does not drive.
  assign oscillator_output = ~oscillator_input;

  // ========================================================================
  // Link domain: receive
  // Deselect clears all frame state, so the next frame opens with a command.
  assign link_rst = rst | slave_select_n;

  assign rx_byte   = {shift_q, mosi_in};
  assign byte_done = (bit_cnt_q == 3'h7);
  assign cmd       = srcp_pkg::srcp_command_type'(rx_byte);

  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= rx_byte[6:0];
    end
  end

  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      in_phase_q <= srcp_pkg::srcp_phase_command;
      addr_q     <= 5'h00;
      write_q    <= 1'b0;
    end else if (byte_done) begin
      if (in_phase_q == srcp_pkg::srcp_phase_command) begin
        in_phase_q <= srcp_pkg::srcp_phase_data;
        addr_q     <= cmd.reg_sel;
        write_q    <= cmd.write;
      end else if (addr_q > `SRCP_LAST_FIFO_REG && addr_q < `SRCP_LAST_REG) begin
        addr_q <= addr_q + 5'h01;
      end
    end
  end

  // ========================================================================
  // Link domain: hand-over to the core
  // Toggles are not cleared by deselect: a write finishing on the last edge
  // of a frame must still reach the core after select rises.
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      wr_tgl_q  <= 1'b0;
      ack_tgl_q <= 1'b0;
      wr_word_q <= '0;
    end else if (!slave_select_n && byte_done) begin
      if (in_phase_q == srcp_pkg::srcp_phase_command) begin
        if (cmd.ack) begin
          ack_tgl_q <= ~ack_tgl_q;
        end
      end else if (write_q) begin
        wr_tgl_q       <= ~wr_tgl_q;
        wr_word_q.addr <= addr_q;
        wr_word_q.data <= rx_byte;
      end
    end
  end

  // ========================================================================
  // Link domain: transmit
  // The snapshot is frozen from two cycles after select falls, so these reads are stable words.
  assign full_duplex = snap_q[`SRCP_REG_PIN_CTL][`SRCP_FULL_DUPLEX_BIT];

  assign status_byte = {snap_q[`SRCP_REG_USB_EVENT][`SRCP_SUSPEND_BIT],
                        snap_q[`SRCP_REG_USB_EVENT][`SRCP_BUS_RESET_BIT],
                        snap_q[`SRCP_REG_EP_EVENT][5:0]};

  always_comb begin
    if (addr_q <= `SRCP_LAST_REG) begin
      rd_byte = snap_q[addr_q];
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(negedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      out_cnt_q   <= 3'h0;
      out_phase_q <= srcp_pkg::srcp_phase_command;
    end else begin
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h7) begin
        out_phase_q <= srcp_pkg::srcp_phase_data;
      end
    end
  end

  always_comb begin
    if (out_phase_q == srcp_pkg::srcp_phase_command) begin
      tx_byte = status_byte;
    end else begin
      tx_byte = rd_byte;
    end
  end

  assign tx_bit   = tx_byte[3'h7 - out_cnt_q];
  assign miso_out = tx_bit;
  assign mosi_out = tx_bit;

  // Select gates the drivers directly, as a pad enable would
  assign miso_oe_n = link_rst | ~full_duplex;
  assign mosi_oe_n = link_rst | full_duplex | write_q |
                     (out_phase_q == srcp_pkg::srcp_phase_command);

  // ========================================================================
  // Core domain: synchronisers
  srcp_sync #(
    .WIDTH       (1),
    .RESET_LEVEL (1'b1)
  ) u_select_sync (
    .clk      (sys_clk),
    .rst      (rst),
    .async_in (slave_select_n),
    .sync_out (select_n_s)
  );

  assign cross_in = {general_inputs, bus_power_compare_input, wr_tgl_q, ack_tgl_q};

  srcp_sync #(
    .WIDTH       (7),
    .RESET_LEVEL (1'b0)
  ) u_level_sync (
    .clk      (sys_clk),
    .rst      (rst),
    .async_in (cross_in),
    .sync_out (cross_s)
  );

  assign gpin_s    = cross_s[6:3];
  assign vbus_s    = cross_s[2];
  assign wr_tgl_s  = cross_s[1];
  assign ack_tgl_s = cross_s[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_tgl_prev_q  <= 1'b0;
      ack_tgl_prev_q <= 1'b0;
      vbus_prev_q    <= 1'b0;
    end else begin
      wr_tgl_prev_q  <= wr_tgl_s;
      ack_tgl_prev_q <= ack_tgl_s;
      vbus_prev_q    <= vbus_s;
    end
  end

  assign wr_event  = wr_tgl_s ^ wr_tgl_prev_q;
  assign ack_event = ack_tgl_s ^ ack_tgl_prev_q;
  assign vbus_rise = vbus_s & ~vbus_prev_q;
  assign vbus_fall = ~vbus_s & vbus_prev_q;

  // ========================================================================
  // Core domain: register file
  function automatic logic [7:0] write_mask(input logic [4:0] addr);
    if (addr <= `SRCP_LAST_FIFO_REG) begin
      write_mask = `SRCP_MASK_ALL;
    end else if (addr <= `SRCP_REG_BYTE_COUNT_HI || addr == `SRCP_REG_EP_STALL) begin
      write_mask = `SRCP_MASK_LOW7;
    end else if (addr == `SRCP_REG_TOGGLES || addr == `SRCP_REG_USB_CTL) begin
      write_mask = `SRCP_MASK_HIGH6;
    end else if (addr == `SRCP_REG_EP_EVENT || addr == `SRCP_REG_EP_ENABLE) begin
      write_mask = `SRCP_MASK_LOW6;
    end else if (addr == `SRCP_REG_CPU_CTL) begin
      write_mask = `SRCP_MASK_BIT0;
    end else if (addr == `SRCP_REG_REVISION || addr == `SRCP_REG_FN_ADDR) begin
      write_mask = `SRCP_MASK_NONE;
    end else if (addr == `SRCP_REG_IO_PIN) begin
      write_mask = `SRCP_MASK_GP_OUT;
    end else begin
      write_mask = `SRCP_MASK_ALL;
    end
  endfunction

  always_comb begin
    logic [7:0] mask;
    mask = write_mask(wr_word_q.addr);
    for (int i = 0; i < `SRCP_REG_COUNT; i++) begin
      regs_d[i] = regs_q[i];
    end
    // Addresses above the last register are dropped
    if (wr_event && wr_word_q.addr <= `SRCP_LAST_REG) begin
      if (wr_word_q.addr == `SRCP_REG_EP_EVENT || wr_word_q.addr == `SRCP_REG_USB_EVENT) begin
        regs_d[wr_word_q.addr] = regs_q[wr_word_q.addr] & ~(wr_word_q.data & mask);
      end else begin
        regs_d[wr_word_q.addr] = (regs_q[wr_word_q.addr] & ~mask) |
                                 (wr_word_q.data & mask);
      end
    end
    // Sets come after the write so an event never loses to a clear
    regs_d[`SRCP_REG_EP_EVENT][5:0] = regs_d[`SRCP_REG_EP_EVENT][5:0] |
                                      usb_events[5:0];
    regs_d[`SRCP_REG_USB_EVENT][`SRCP_SUSPEND_BIT] =
      regs_d[`SRCP_REG_USB_EVENT][`SRCP_SUSPEND_BIT] | usb_events.suspend_event;
    regs_d[`SRCP_REG_USB_EVENT][`SRCP_BUS_RESET_BIT] =
      regs_d[`SRCP_REG_USB_EVENT][`SRCP_BUS_RESET_BIT] | usb_events.bus_reset_event;
    regs_d[`SRCP_REG_USB_EVENT][`SRCP_VBUS_ON_BIT] =
      regs_d[`SRCP_REG_USB_EVENT][`SRCP_VBUS_ON_BIT] | vbus_rise;
    regs_d[`SRCP_REG_USB_EVENT][`SRCP_VBUS_OFF_BIT] =
      regs_d[`SRCP_REG_USB_EVENT][`SRCP_VBUS_OFF_BIT] | vbus_fall;
    regs_d[`SRCP_REG_EP_STALL][`SRCP_ACK_BIT] =
      regs_d[`SRCP_REG_EP_STALL][`SRCP_ACK_BIT] | ack_event;
    regs_d[`SRCP_REG_IO_PIN][7:4] = gpin_s;
    regs_d[`SRCP_REG_REVISION]    = REVISION_CODE;
  end

  // Reset clears the duplex bit, leaving the port in half-duplex
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `SRCP_REG_COUNT; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < `SRCP_REG_COUNT; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ========================================================================
  // Core domain: snapshot seen by the link
  // Frozen two cycles after select falls; a write made earlier in the same
  // frame is therefore not visible to a read until the next frame.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `SRCP_REG_COUNT; i++) begin
        snap_q[i] <= 8'h00;
      end
    end else if (select_n_s) begin
      for (int i = 0; i < `SRCP_REG_COUNT; i++) begin
        snap_q[i] <= regs_q[i];
      end
    end
  end

  // ========================================================================
  // Core domain: pins
  assign irq_pending =
    regs_q[`SRCP_REG_CPU_CTL][`SRCP_INT_ENABLE_BIT] &
    (|((regs_q[`SRCP_REG_USB_EVENT] & regs_q[`SRCP_REG_USB_ENABLE]) |
       (regs_q[`SRCP_REG_EP_EVENT] & regs_q[`SRCP_REG_EP_ENABLE])));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_active_q <= 1'b0;
      gpout_q      <= 4'h0;
    end else begin
      irq_active_q <= irq_pending;
      gpout_q      <= regs_q[`SRCP_REG_IO_PIN][3:0];
    end
  end

  assign general_outputs = gpout_q;

  // Level mode pulls low as open drain; otherwise push-pull with set polarity
  always_comb begin
    if (regs_q[`SRCP_REG_PIN_CTL][`SRCP_INT_LEVEL_BIT]) begin
      interrupt_out  = 1'b0;
      interrupt_oe_n = ~irq_active_q;
    end else begin
      interrupt_out  = irq_active_q ~^ regs_q[`SRCP_REG_PIN_CTL][`SRCP_INT_POS_BIT];
      interrupt_oe_n = 1'b0;
    end
  end

endmodule

// ===== srcp_spi_register_command_port_test.sv
// Self-checking bench for the SPI register command port
`timescale 1ns/1ps
module srcp_spi_register_command_port_test;
  logic        sys_clk;
  logic        rst;
  logic        spi_clk;
  logic        slave_select_n;
  logic        mosi_in;
  logic        mosi_out;
  logic        mosi_oe_n;
  logic        miso_out;
  logic        miso_oe_n;
  logic [3:0]  general_inputs;
  logic [3:0]  general_outputs;
  logic        bus_power;
  logic        osc_in;
  logic        osc_out;
  logic [7:0]  usb_events;
  logic        interrupt_out;
  logic        interrupt_oe_n;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic        saw_miso = 1'b0;
  logic [7:0]  tx[$];
  logic [7:0]  rx[$];
  // Register, written byte, expected read back
  logic [20:0] rows[9] = '{21'h0cff3f, 21'h10ff01, 21'h0ea5a5, 21'h12ff5a, 21'h13ff00,
                           21'h14f696, 21'h15ff00, 21'h0afffc, 21'h09ff7f};

  srcp_spi_register_command_port #(.REVISION_CODE(8'h5a)) dut (
    .sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .slave_select_n(slave_select_n),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .general_inputs(general_inputs), .general_outputs(general_outputs),
    .bus_power_compare_input(bus_power), .oscillator_input(osc_in),
    .oscillator_output(osc_out), .usb_events(usb_events), .interrupt_out(interrupt_out),
    .interrupt_oe_n(interrupt_oe_n));

  srcp_spi_master_model m (
    .spi_clk(spi_clk), .slave_select_n(slave_select_n), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n));

  // ==========================================================================
  // Clocks, timeout and monitors
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Even half period never meets a rising core edge
  initial begin
    osc_in = 1'b0;
    forever #42 osc_in = ~osc_in;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (!miso_oe_n) saw_miso <= 1'b1;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] cmdb(input logic [4:0] r, input logic w, input logic a);
    return {r, 1'b0, w, a};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, input int n);
    tx = {cmd};
    repeat (n) tx.push_back(d);
    m.frame(tx, rx);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    usb_events = 8'h00;
    general_inputs = 4'h9;
    bus_power = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    xfer(cmdb(5'h11, 1'b0, 1'b0), 8'h00, 1);
    check(rx[1], 8'h00, "duplex mode at reset");
    foreach (rows[i]) begin
      xfer(cmdb(rows[i][20:16], 1'b1, 1'b0), rows[i][15:8], 1);
      xfer(cmdb(rows[i][20:16], 1'b0, 1'b0), 8'h00, 1);
      check(rx[1], rows[i][7:0], "register row");
    end
    check({4'h0, general_outputs}, 8'h06, "general outputs");
    $display("register rows done");
    tx = '{cmdb(5'h13, 1'b1, 1'b0), 8'h11, 8'h22, 8'h33};
    m.frame(tx, rx);
    xfer(cmdb(5'h12, 1'b0, 1'b0), 8'h00, 4);
    check(rx[2], 8'h00, "increment into 19");
    check(rx[3], 8'h93, "increment into 20");
    check(rx[4], 8'h93, "stays at 20");
    // Fifo register keeps its address, so the second byte overwrites the first
    tx = '{cmdb(5'h00, 1'b1, 1'b0), 8'h11, 8'h3c};
    m.frame(tx, rx);
    xfer(cmdb(5'h00, 1'b0, 1'b0), 8'h00, 2);
    check(rx[1], 8'h3c, "fifo first read");
    check(rx[2], 8'h3c, "fifo second read");
    xfer(cmdb(5'h09, 1'b1, 1'b0), 8'h00, 1);
    xfer(cmdb(5'h09, 1'b0, 1'b1), 8'h00, 1);
    xfer(cmdb(5'h09, 1'b0, 1'b0), 8'h00, 1);
    check(rx[1], 8'h40, "ack bit");
    $display("address and ack done");
    for (int v = 1; v >= 0; v--) begin
      @(negedge sys_clk) bus_power = v[0];
      repeat (4) @(negedge sys_clk);
      xfer(cmdb(5'h0d, 1'b0, 1'b0), 8'h00, 1);
      check(rx[1], v[0] ? 8'h40 : 8'h60, "bus power bits");
      // Of the two bus power bits only the power-loss bit is enabled; pin is active-low push-pull here
      check({7'h00, interrupt_out}, {7'h00, v[0]}, "bus power interrupt");
    end
    xfer(cmdb(5'h0d, 1'b1, 1'b0), 8'hff, 1);
    check({7'h00, saw_miso}, 8'h00, "miso in half duplex");
    $display("half duplex done");
    // Level interrupt mode too, so the open drain pin is exercised
    xfer(cmdb(5'h11, 1'b1, 1'b0), 8'h18, 1);
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk) usb_events = 8'h01 << k;
      @(negedge sys_clk) usb_events = 8'h00;
      tx = '{cmdb(5'h0b, 1'b1, 1'b0), 8'hff, 8'h00, 8'hff};
      m.frame(tx, rx);
      check(rx[0], 8'h01 << k, "status byte");
    end
    xfer(cmdb(5'h11, 1'b0, 1'b0), 8'h00, 1);
    check(rx[0], 8'h00, "status cleared");
    check(rx[1], 8'h18, "full duplex read");
    $display("full duplex done");
    @(negedge sys_clk) rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    xfer(cmdb(5'h11, 1'b0, 1'b0), 8'h00, 1);
    check(rx[1], 8'h00, "duplex after reset");
    $display("second reset done");
    end_sim();
  end
endmodule

bind srcp_spi_register_command_port srcp_command_port_sva chk (
  .sys_clk(sys_clk), .rst(rst), .slave_select_n(slave_select_n), .mosi_oe_n(mosi_oe_n),
  .miso_oe_n(miso_oe_n), .general_outputs(general_outputs),
  .oscillator_input(oscillator_input), .oscillator_output(oscillator_output),
  .interrupt_out(interrupt_out), .interrupt_oe_n(interrupt_oe_n));

// ===== srcp_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module srcp_sync #(
  parameter int   WIDTH       = 1,
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= {WIDTH{RESET_LEVEL}};
      sync_out <= {WIDTH{RESET_LEVEL}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
